/* File: hw/cpl_core.sv */
`timescale 1ns/100ps
module cpl_core
    import cpl_pkg::*;
#(
    parameter int FIFO_DEPTH = CPL_FIFO_DEPTH
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic [CPL_ADDR_W-1:0] pixel_index_in,
    input  wire logic                  pixel_blank_n,
    input  wire logic                  host_wr_n,
    input  wire logic                  host_rd_n,
    input  wire logic [1:0]            reg_select,
    input  wire logic [CPL_HOST_W-1:0] host_data_in,
    output logic      [CPL_HOST_W-1:0] host_data_out,
    output logic                       host_data_oe,
    output logic      [CPL_COMP_W-1:0] red_out,
    output logic      [CPL_COMP_W-1:0] green_out,
    output logic      [CPL_COMP_W-1:0] blue_out
);
    localparam int QW = CPL_ADDR_W + CPL_ENTRY_W;

    // ********************************************************
    // host pin synchronisers
    // ********************************************************
    // strobes, select and data all cross from the asynchronous host
    logic [11:0] sync1_reg;
    logic [11:0] sync2_reg;
    logic        wr_d_reg;
    logic        rd_d_reg;
    logic [7:0]  wdata_reg;
    logic [1:0]  wsel_reg;
    logic [1:0]  rsel_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 12'hC00;
            sync2_reg <= 12'hC00;
        end else begin
            sync1_reg <= {host_wr_n, host_rd_n, reg_select, host_data_in};
            sync2_reg <= sync1_reg;
        end
    end

    wire       wr_s   = sync2_reg[11];
    wire       rd_s   = sync2_reg[10];
    wire [1:0] sel_s  = sync2_reg[9:8];
    wire [7:0] din_s  = sync2_reg[7:0];
    // completion on trailing edge, when the host has settled data
    wire       wr_done = wr_s & ~wr_d_reg;
    wire       rd_done = rd_s & ~rd_d_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_d_reg  <= 1'b1;
            rd_d_reg  <= 1'b1;
            wdata_reg <= 8'h00;
            wsel_reg  <= 2'h0;
            rsel_reg  <= 2'h0;
        end else begin
            wr_d_reg  <= wr_s;
            rd_d_reg  <= rd_s;
            wdata_reg <= !wr_s ? din_s : wdata_reg;
            wsel_reg  <= !wr_s ? sel_s : wsel_reg;
            rsel_reg  <= !rd_s ? sel_s : rsel_reg;
        end
    end

    // ********************************************************
    // register decode
    // ********************************************************
    logic [CPL_ADDR_W-1:0]  addr_reg;
    logic [CPL_ADDR_W-1:0]  mask_reg;
    logic [CPL_ENTRY_W-1:0] buf_reg;
    cpl_comp_t              comp_reg;
    logic                   push_pend_reg;
    logic                   fetch_pend_reg;
    logic                   fetch_dly_reg;
    logic [CPL_ENTRY_W-1:0] slot_data_reg;

    wire wr_waddr  = wr_done & (wsel_reg == CPL_SEL_WADDR);
    wire wr_raddr  = wr_done & (wsel_reg == CPL_SEL_RADDR);
    wire wr_colour = wr_done & (wsel_reg == CPL_SEL_COLOUR);
    wire wr_mask   = wr_done & (wsel_reg == CPL_SEL_MASK);
    wire rd_colour = rd_done & (rsel_reg == CPL_SEL_COLOUR) & ~wr_done;
    wire addr_wr   = wr_waddr | wr_raddr;
    wire last_comp = (comp_reg == CPL_COMP_BLUE);
    wire [5:0] wbyte = wdata_reg[CPL_COMP_W-1:0];

    // fifo feeding palette writes
    logic          q_in_ready;
    logic          q_out_valid;
    logic [QW-1:0] q_out_data;
    wire           push_go  = push_pend_reg & q_in_ready;
    // fetch waits behind queued writes so reads see fresh data
    wire           fetch_go = fetch_pend_reg & ~push_pend_reg & ~q_out_valid;
    wire           drain_go = q_out_valid & ~fetch_go;
    wire           host_slot = fetch_go | drain_go;

    wire [CPL_ADDR_W-1:0] addr_inc = addr_reg + 8'h01;
    wire [CPL_ADDR_W-1:0] addr_next =
        addr_wr              ? wdata_reg :
        (push_go | fetch_go) ? addr_inc  : addr_reg;

    // buffer field update for a colour byte write
    wire [CPL_ENTRY_W-1:0] buf_wr =
        (comp_reg == CPL_COMP_RED)   ? {wbyte, buf_reg[11:0]} :
        (comp_reg == CPL_COMP_GREEN) ? {buf_reg[17:12], wbyte, buf_reg[5:0]} :
                                       {buf_reg[17:6], wbyte};
    wire [CPL_ENTRY_W-1:0] buf_next =
        wr_colour     ? buf_wr        :
        fetch_dly_reg ? slot_data_reg : buf_reg;

    wire cyc_adv = wr_colour | rd_colour;
    wire [1:0] comp_inc = comp_reg + 2'h1;
    cpl_comp_t comp_next;
    assign comp_next =
        addr_wr                ? CPL_COMP_RED :
        (cyc_adv & last_comp)  ? CPL_COMP_RED :
        cyc_adv                ? cpl_comp_t'(comp_inc) : comp_reg;

    wire push_next  = (wr_colour & last_comp) | (push_pend_reg & ~push_go);
    wire fetch_next = wr_raddr | (rd_colour & last_comp)
                    | (fetch_pend_reg & ~fetch_go);

    // ********************************************************
    // host registers
    // ********************************************************
    // mask is the only state a mask write may touch
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg       <= CPL_ADDR_RST;
            mask_reg       <= CPL_MASK_RST;
            buf_reg        <= CPL_BUF_RST;
            comp_reg       <= CPL_COMP_RED;
            push_pend_reg  <= 1'b0;
            fetch_pend_reg <= 1'b0;
            fetch_dly_reg  <= 1'b0;
        end else begin
            addr_reg       <= addr_next;
            mask_reg       <= wr_mask ? wdata_reg : mask_reg;
            buf_reg        <= buf_next;
            comp_reg       <= comp_next;
            push_pend_reg  <= push_next;
            fetch_pend_reg <= fetch_next;
            fetch_dly_reg  <= fetch_go;
        end
    end

    cpl_fifo #(
        .WIDTH (QW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (push_pend_reg),
        .in_ready  (q_in_ready),
        .in_data   ({addr_reg, buf_reg}),
        .out_valid (q_out_valid),
        .out_ready (~fetch_go),
        .out_data  (q_out_data)
    );

    // ********************************************************
    // host read-back
    // ********************************************************
    wire [5:0] rbyte =
        (comp_reg == CPL_COMP_RED)   ? buf_reg[17:12] :
        (comp_reg == CPL_COMP_GREEN) ? buf_reg[11:6]  : buf_reg[5:0];
    wire [7:0] dout_mux =
        (sel_s == CPL_SEL_COLOUR) ? {2'h0, rbyte} :
        (sel_s == CPL_SEL_MASK)   ? mask_reg      : addr_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_data_out <= 8'h00;
            host_data_oe  <= 1'b0;
        end else begin
            host_data_out <= dout_mux;
            host_data_oe  <= ~rd_s & wr_s;
        end
    end

    // ********************************************************
    // pixel path and palette
    // ********************************************************
    logic [CPL_ENTRY_W-1:0] pal_mem [CPL_ENTRIES];
    logic [CPL_ADDR_W-1:0]  pix_idx_reg;
    logic [2:0]             blank_pipe_reg;
    logic [CPL_ENTRY_W-1:0] lut_data_reg;

    wire [CPL_ADDR_W-1:0] pix_addr = pix_idx_reg & mask_reg;
    // host slot uses the raw address, never the mask
    wire [CPL_ADDR_W-1:0] slot_addr =
        fetch_go ? addr_reg : drain_go ? q_out_data[QW-1:CPL_ENTRY_W]
                 : pix_addr;

    always_ff @(posedge core_clk) begin
        slot_data_reg <= pal_mem[slot_addr];
        if (drain_go) begin
            pal_mem[slot_addr] <= q_out_data[CPL_ENTRY_W-1:0];
        end
    end

    // stage 0 sample, stage 1 lookup, stage 2 hold, stage 3 output
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pix_idx_reg    <= 8'h00;
            blank_pipe_reg <= 3'h0;
            lut_data_reg   <= CPL_BUF_RST;
            red_out        <= 6'h00;
            green_out      <= 6'h00;
            blue_out       <= 6'h00;
        end else begin
            pix_idx_reg    <= pixel_index_in;
            blank_pipe_reg <= {blank_pipe_reg[1:0], pixel_blank_n};
            lut_data_reg   <= slot_data_reg;
            red_out   <= blank_pipe_reg[2]
                       ? lut_data_reg[CPL_RED_LSB+:CPL_COMP_W] : 6'h00;
            green_out <= blank_pipe_reg[2]
                       ? lut_data_reg[CPL_GREEN_LSB+:CPL_COMP_W] : 6'h00;
            blue_out  <= blank_pipe_reg[2]
                       ? lut_data_reg[CPL_BLUE_LSB+:CPL_COMP_W] : 6'h00;
        end
    end

    // ********************************************************
    // assertions
    // ********************************************************
    AST_BLANK_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$past(pixel_blank_n, 4) |->
            (red_out == 6'h00 && green_out == 6'h00 && blue_out == 6'h00))
        else $error("blanked pixel not zero at output");
    AST_PIPE_SPLIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##4 $past(pixel_blank_n, 4) |->
            {red_out, green_out, blue_out} == $past(slot_data_reg, 2))
        else $error("colour split or latency wrong");
    // only unblanked pixels: entries never written hold no defined value
    AST_MASK_LOOKUP: assert property (@(posedge core_clk) disable iff (!rst_n)
        !host_slot && blank_pipe_reg[0]
            |=> slot_data_reg == pal_mem[$past(pix_idx_reg & mask_reg)])
        else $error("pixel lookup address not masked");
    AST_ABORT_SEQ: assert property (@(posedge core_clk) disable iff (!rst_n)
        addr_wr |=> comp_reg == CPL_COMP_RED && addr_reg == $past(wdata_reg))
        else $error("address write did not restart sequence");
    AST_MASK_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_mask && !fetch_go && !push_go |=> $stable(addr_reg) && $stable(comp_reg))
        else $error("mask write disturbed address or sequence");
    AST_WRITE_STORE: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_colour && last_comp |=> push_pend_reg ##[0:40] push_go)
        else $error("blue write not queued for store");
    AST_FETCH_INC: assert property (@(posedge core_clk) disable iff (!rst_n)
        fetch_go && !addr_wr |=> addr_reg == $past(addr_reg) + 8'h01
            ##1 buf_reg == pal_mem[$past(addr_reg, 2)] || $past(wr_colour))
        else $error("fetch did not load buffer and increment");
    AST_READ_TOP_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(sel_s) == CPL_SEL_COLOUR |-> host_data_out[7:6] == 2'h0)
        else $error("colour read top bits not zero");
    AST_ADDR_ALIAS: assert property (@(posedge core_clk) disable iff (!rst_n)
        ($past(sel_s) == CPL_SEL_WADDR || $past(sel_s) == CPL_SEL_RADDR)
            |-> host_data_out == $past(addr_reg))
        else $error("address read-back differs between selects");
    AST_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (push_go || fetch_go) && !addr_wr && addr_reg == 8'hFF
            |=> addr_reg == 8'h00)
        else $error("address did not wrap to zero");
endmodule

/* File: hw/cpl_fifo.sv */
`timescale 1ns/100ps
module cpl_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
            rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
            count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: hw/cpl_pkg.sv */
// Contract
// - Palette holds 256 entries of 18 bits, pixel-readable and host read/write.
// - Masked 8-bit index addresses palette; result splits into three 6-bit words.
// - Index and blanking sampled each edge, output after three further edges.
// - Blanking low forces zero into all three colour channels.
// - Select 00 write address, 11 read address, 01 colour buffer, 10 mask.
// - Host data port is 8 bits; one byte per value or component.
// - Write address, then red, green, blue; after blue store entry, increment.
// - Read address write copies addressed entry to buffer, then increments.
// - Host reads red, green, blue; after blue reload buffer and increment.
// - Any address update abandons a partial colour read or write sequence.
// - Host accesses are asynchronous; transfers synchronised between accesses.
// - Pixel lookup address is index AND pixel mask.
// - Mask writes leave address, buffer and sequence untouched.
// - Colour writes keep low six bits; reads return zero in top two.
// - Read at select 00 returns the same address as select 11.
// - Mask is never applied to the host palette address.
// - Each buffer/palette transfer replaces the lookup for one pixel.
package cpl_pkg;
    localparam int        CPL_ENTRIES    = 256;
    localparam int        CPL_ADDR_W     = 8;
    localparam int        CPL_COMP_W     = 6;
    localparam int        CPL_ENTRY_W    = 18;
    localparam int        CPL_HOST_W     = 8;
    localparam int        CPL_FIFO_DEPTH = 16;
    localparam int        CPL_PIPE_EDGES = 3;
    // register select codes
    localparam logic [1:0] CPL_SEL_WADDR = 2'h0;
    localparam logic [1:0] CPL_SEL_COLOUR = 2'h1;
    localparam logic [1:0] CPL_SEL_MASK  = 2'h2;
    localparam logic [1:0] CPL_SEL_RADDR = 2'h3;
    // colour field positions inside an entry
    localparam int        CPL_RED_LSB    = 12;
    localparam int        CPL_GREEN_LSB  = 6;
    localparam int        CPL_BLUE_LSB   = 0;
    // reset values of control state
    localparam logic [7:0]  CPL_ADDR_RST   = 8'h00;
    localparam logic [7:0]  CPL_MASK_RST   = 8'hFF;
    localparam logic [17:0] CPL_BUF_RST    = 18'h00000;
    typedef enum logic [1:0] {
        CPL_COMP_RED,
        CPL_COMP_GREEN,
        CPL_COMP_BLUE
    } cpl_comp_t;
endpackage

/* File: verif/cpl_host_model.sv */
`timescale 1ns/100ps
module cpl_host_model
    import cpl_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic [CPL_HOST_W-1:0] host_data_out,
    input  wire logic                  host_data_oe,
    output logic                       host_wr_n,
    output logic                       host_rd_n,
    output logic      [1:0]            reg_select,
    output logic      [CPL_HOST_W-1:0] host_data_in
);
    // ****
    // host strobes
    // ****
    int stretch = 0;

    initial begin
        host_wr_n    = 1'b1;
        host_rd_n    = 1'b1;
        reg_select   = CPL_SEL_MASK;
        host_data_in = 8'h00;
    end

    // one byte per access on the 8-bit port
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(negedge core_clk);
        reg_select   = s;
        host_data_in = d;
        host_wr_n    = 1'b0;
        repeat (4 + stretch) @(negedge core_clk);
        host_wr_n = 1'b1;
        // hold past the synchronised rise, then let the lines wander
        repeat (4) @(negedge core_clk);
        host_data_in = ~d;
        repeat (8) @(negedge core_clk);
    endtask

    task automatic rd(input logic [1:0] s, output logic [7:0] d);
        @(negedge core_clk);
        reg_select = s;
        host_rd_n  = 1'b0;
        repeat (5 + stretch) @(negedge core_clk);
        d = (host_data_oe === 1'b1) ? host_data_out : 8'hXX;
        host_rd_n = 1'b1;
        repeat (12) @(negedge core_clk);
    endtask
endmodule

/* File: verif/tb.sv */
`timescale 1ns/100ps
module tb
    import cpl_pkg::*;
;
    // ****
    // signals
    // ****
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic [7:0]  pix      = 8'h00;
    // blanked outside pixel tests: unwritten entries hold no colour
    logic        blank_n  = 1'b0;
    logic        wr_n, rd_n, oe;
    logic [1:0]  sel;
    logic [7:0]  din, dout, ptr, rb;
    logic [5:0]  red, green, blue;
    logic [17:0] mem [256];
    int          failures    = 0;
    int          checks_done = 0;
    int          cycles      = 0;

    always #12.5 core_clk = ~core_clk;

    cpl_core dut (.core_clk(core_clk), .rst_n(rst_n),
        .pixel_index_in(pix), .pixel_blank_n(blank_n),
        .host_wr_n(wr_n), .host_rd_n(rd_n), .reg_select(sel),
        .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
        .red_out(red), .green_out(green), .blue_out(blue));

    cpl_host_model host (.core_clk(core_clk), .host_data_out(dout),
        .host_data_oe(oe), .host_wr_n(wr_n), .host_rd_n(rd_n),
        .reg_select(sel), .host_data_in(din));

    // ****
    // helpers
    // ****
    task automatic chk(input string w, input logic [17:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", w, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic rd_chk(input string w, input logic [1:0] s,
                          input logic [7:0] e);
        host.rd(s, rb);
        chk(w, {10'h000, rb}, {10'h000, e});
    endtask

    task automatic seta(input logic [1:0] s, input logic [7:0] a);
        host.wr(s, a);
        ptr = (s == CPL_SEL_RADDR) ? a + 8'h01 : a;
    endtask

    // top bits set on purpose: only the low six may land
    task automatic put(input logic [17:0] e, input bit mid = 1'b0);
        host.wr(CPL_SEL_COLOUR, {2'h3, e[17:12]});
        if (mid) begin
            host.wr(CPL_SEL_MASK, 8'h30);
        end
        host.wr(CPL_SEL_COLOUR, {2'h3, e[11:6]});
        host.wr(CPL_SEL_COLOUR, {2'h3, e[5:0]});
        mem[ptr] = e;
        ptr++;
    endtask

    task automatic get(input logic [7:0] a);
        rd_chk("red", CPL_SEL_COLOUR, {2'h0, mem[a][17:12]});
        rd_chk("green", CPL_SEL_COLOUR, {2'h0, mem[a][11:6]});
        rd_chk("blue", CPL_SEL_COLOUR, {2'h0, mem[a][5:0]});
        ptr++;
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_regs;
        rd_chk("address", CPL_SEL_WADDR, CPL_ADDR_RST);
        rd_chk("mask", CPL_SEL_MASK, CPL_MASK_RST);
        host.wr(CPL_SEL_MASK, 8'h3C);
        rd_chk("mask", CPL_SEL_MASK, 8'h3C);
        seta(CPL_SEL_WADDR, 8'h5A);
        rd_chk("address", CPL_SEL_RADDR, 8'h5A);
        rd_chk("address", CPL_SEL_WADDR, 8'h5A);
        $display("test regs done");
    endtask

    task automatic t_seq;
        seta(CPL_SEL_WADDR, 8'hFE);
        put(18'h2A5C3);
        put(18'h15A3C);
        put(18'h0C3F0);
        rd_chk("address", CPL_SEL_WADDR, ptr);
        seta(CPL_SEL_RADDR, 8'hFE);
        get(8'hFE);
        get(8'hFF);
        rd_chk("address", CPL_SEL_RADDR, ptr);
        $display("test sequence done");
    endtask

    task automatic t_abort;
        host.stretch = 3;
        seta(CPL_SEL_WADDR, 8'h10);
        host.wr(CPL_SEL_COLOUR, 8'h3F);
        host.wr(CPL_SEL_COLOUR, 8'h3F);
        seta(CPL_SEL_WADDR, 8'h10);
        put(18'h0F0F1);
        put(18'h30F0E);
        host.stretch = 0;
        seta(CPL_SEL_WADDR, 8'h20);
        put(18'h3C30C, 1'b1);
        put(18'h03CF3);
        seta(CPL_SEL_RADDR, 8'h10);
        rd_chk("red", CPL_SEL_COLOUR, {2'h0, mem[8'h10][17:12]});
        seta(CPL_SEL_RADDR, 8'h20);
        get(8'h20);
        seta(CPL_SEL_RADDR, 8'h10);
        get(8'h10);
        rd_chk("address", CPL_SEL_WADDR, ptr);
        rd_chk("mask", CPL_SEL_MASK, 8'h30);
        $display("test abort done");
    endtask

    // stream of two indices back to back, blanking now and then
    task automatic t_pix(input logic [7:0] m, a, b);
        logic [7:0]  ix [16];
        logic        bl [16];
        logic [17:0] e;
        host.wr(CPL_SEL_MASK, m);
        for (int i = 0; i < 16; i++) begin
            @(negedge core_clk);
            ix[i]   = i[0] ? b : a;
            bl[i]   = (i % 5) != 3;
            pix     = ix[i];
            blank_n = bl[i];
            if (i >= 4) begin
                e = bl[i-4] ? mem[ix[i-4] & m] : 18'h00000;
                chk("colour", {red, green, blue}, e);
            end
        end
        blank_n = 1'b0;
        $display("test pixel path done");
    endtask

    // ****
    // main sequence and watchdog
    // ****
    initial begin
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        t_regs;
        t_seq;
        t_abort;
        t_pix(8'h30, 8'h1F, 8'h2A);
        t_pix(8'hFF, 8'hFE, 8'hFF);
        end_of_test;
    end

    // about 1000 cycles expected; three times that means a hang
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_of_test;
        end
    end
endmodule
